/* File: logic/iorac_defs.vh */
`ifndef IORAC_DEFS_VH
`define IORAC_DEFS_VH
// instruction codes
`define IORAC_CMD_OUTPUT_SET 8'h0E
`define IORAC_CMD_INPUT_READ 8'h0F
`define IORAC_CMD_ACCUM 8'h13
`define IORAC_CMD_COMPARE 8'h14
// reply status codes
`define IORAC_ST_OK 8'h64
`define IORAC_ST_BAD_CMD 8'h02
`define IORAC_ST_BAD_TYPE 8'h03
`define IORAC_ST_BAD_VALUE 8'h04
// banks
`define IORAC_BANK_DIG_IN 8'h00
`define IORAC_BANK_ANA_IN 8'h01
`define IORAC_BANK_DIG_OUT 8'h02
// ports
`define IORAC_PORT_ALL 8'hFF
`define IORAC_PORT_VOLT 8'h08
`define IORAC_PORT_TEMP 8'h09
// calculate operations
`define IORAC_OP_ADD 8'h00
`define IORAC_OP_SUB 8'h01
`define IORAC_OP_MUL 8'h02
`define IORAC_OP_DIV 8'h03
`define IORAC_OP_MOD 8'h04
`define IORAC_OP_AND 8'h05
`define IORAC_OP_OR 8'h06
`define IORAC_OP_XOR 8'h07
`define IORAC_OP_NOT 8'h08
`define IORAC_OP_LOAD 8'h09
// flag bit positions
`define IORAC_FLAG_ZE 0
`define IORAC_FLAG_EQ 1
`define IORAC_FLAG_GT 2
`define IORAC_FLAG_LT 3
// reset values
`define IORAC_ACC_RST 32'h00000000
`define IORAC_FLAGS_RST 4'h0
`define IORAC_OUT_RST 1'b0
// timing: divider needs one cycle per quotient bit
`define IORAC_DIV_CYCLES 6'h20
`endif

/* File: logic/iorac_divider.v */
`timescale 1ns/1ns
`include "iorac_defs.vh"
// signed restoring divider, truncating toward zero like c
module iorac_divider (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // request
  input wire start_in,
  input wire [31:0] dividend_in,
  input wire [31:0] divisor_in,
  // answer
  output reg done_out,
  output reg [31:0] quot_out,
  output reg [31:0] rem_out
);
  reg [31:0] num_reg; // magnitude of dividend, shifted out
  reg [31:0] den_reg; // magnitude of divisor
  reg [32:0] rem_reg; // partial remainder
  reg [31:0] q_reg; // quotient bits
  reg [5:0] cnt_reg; // bits left
  reg busy_reg;
  reg qneg_reg; // quotient sign
  reg rneg_reg; // remainder follows dividend sign
  wire [32:0] trial = {rem_reg[31:0], num_reg[31]} - {1'b0, den_reg};
  // one quotient bit per cycle keeps the adder small
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      busy_reg <= 1'b0;
      done_out <= 1'b0;
      quot_out <= 32'h00000000;
      rem_out <= 32'h00000000;
      num_reg <= 32'h00000000;
      den_reg <= 32'h00000000;
      rem_reg <= 33'h000000000;
      q_reg <= 32'h00000000;
      cnt_reg <= 6'h00;
      qneg_reg <= 1'b0;
      rneg_reg <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_reg) begin
        busy_reg <= 1'b1;
        num_reg <= dividend_in[31] ? (32'h00000000 - dividend_in) : dividend_in;
        den_reg <= divisor_in[31] ? (32'h00000000 - divisor_in) : divisor_in;
        qneg_reg <= dividend_in[31] ^ divisor_in[31];
        rneg_reg <= dividend_in[31];
        rem_reg <= 33'h000000000;
        q_reg <= 32'h00000000;
        cnt_reg <= `IORAC_DIV_CYCLES;
      end else if (busy_reg) begin
        if (cnt_reg == 6'h00) begin
          // finished: apply signs
          busy_reg <= 1'b0;
          done_out <= 1'b1;
          quot_out <= qneg_reg ? (32'h00000000 - q_reg) : q_reg;
          rem_out <= rneg_reg ? (32'h00000000 - rem_reg[31:0]) : rem_reg[31:0];
        end else begin
          num_reg <= {num_reg[30:0], 1'b0};
          if (!trial[32]) begin
            rem_reg <= trial;
            q_reg <= {q_reg[30:0], 1'b1};
          end else begin
            rem_reg <= {rem_reg[31:0], num_reg[31]};
            q_reg <= {q_reg[30:0], 1'b0};
          end
          cnt_reg <= cnt_reg - 6'h01;
        end
      end
    end
  end
endmodule // iorac_divider

/* File: logic/iorac_unit.v */
// Function
// R01 - input read: code 15, port, bank 0-2
// R02 - digital reads 0/1, analog 0..4095
// R03 - standalone: read value loads accumulator
// R04 - direct: read value only in reply
// R05 - read reply status 100, port state
// R06 - bank 0: inputs 0-2 as bits
// R07 - port 255 bank 0: bit vector to accumulator
// R08 - bank 1: analog, volts 8, temperature 9
// R09 - bank 2 reads back driven output
// R10 - calculate: code 19, operand, ten ops
// R11 - type byte selects the operation
// R12 - calculate result written into accumulator
// R13 - direct calculate reply echoes the operand
// R14 - compare: code 20, accumulator vs operand
// R15 - compare sets flags, accumulator kept
// R16 - output set: code 14, bank 2 port 0
// R17 - value is signed 32 bit
// R18 - checksum is byte sum of frame
`timescale 1ns/1ns
`include "iorac_defs.vh"
module iorac_unit (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // decoded command, one-cycle strobe; frame checksum already verified upstream
  input wire cmd_valid_in,
  input wire [7:0] cmd_instr_in,
  input wire [7:0] cmd_type_in,
  input wire [7:0] cmd_bank_in,
  input wire [31:0] cmd_value_in,
  input wire standalone_in,
  // general purpose pins and converter results
  input wire [2:0] gp_input_pins_in,
  input wire [11:0] gp_input_zero_adc_in,
  input wire [11:0] supply_tenths_in,
  input wire [11:0] temp_deg_in,
  // reply
  output reg rep_valid_out,
  output reg [7:0] rep_status_out,
  output reg [7:0] rep_instr_out,
  output reg [31:0] rep_value_out,
  output reg [7:0] rep_sum_out,
  // state
  output reg [31:0] accum_out,
  output reg [3:0] flags_out,
  output reg gp_output_zero_out,
  output reg busy_out
);
  // one-hot states; any other code falls back to idle through the default branch
  localparam ST_IDLE = 3'b001; // waiting for command
  localparam ST_DIV = 3'b010; // divider running
  localparam ST_REPLY = 3'b100; // reply pulse
  reg [2:0] state_reg;
  reg [2:0] state_next;
  // two-stage synchroniser for the pins
  reg [2:0] pin_meta_reg;
  reg [2:0] pin_sync_reg;
  // the command strobe lasts one cycle, so a divide keeps its own copy
  // of the operation and operand until the divider has finished
  // held command fields for the divide path
  reg [7:0] hold_type_reg;
  reg [31:0] hold_value_reg;
  reg hold_sa_reg;
  // the divider reads the accumulator directly; nothing else writes it
  // while the state machine sits in the divide state
  // divider link
  reg div_start_reg;
  wire div_done;
  wire [31:0] div_quot;
  wire [31:0] div_rem;
  // decoded from the live command fields; only used in the cycle of the strobe
  // combinational results
  reg [31:0] read_val;
  reg read_ok;
  reg read_all;
  reg [31:0] accumulator_cmd_a_val;
  reg accumulator_cmd_a_ok;
  // signed views for multiply and compare; add and subtract wrap the same way
  wire signed [31:0] acc_s = accum_out;
  wire signed [31:0] opr_s = cmd_value_in;
  // reply checksum: host addr, target addr, status, instr, value bytes
  // both addresses are fixed here, so only six bytes of the sum vary
  function [7:0] rep_sum;
    input [7:0] status;
    input [7:0] instr;
    input [31:0] value;
    begin
      rep_sum = 8'h02 + 8'h01 + status + instr + value[31:24] + value[23:16] +
        value[15:8] + value[7:0]; // R18
    end
  endfunction
  // divide and modulo take the multi-cycle path; this decode is used in
  // the state machine and in the execution block alike
  function is_div_op;
    input [7:0] op;
    begin
      is_div_op = (op == `IORAC_OP_DIV) || (op == `IORAC_OP_MOD);
    end
  endfunction
  // pins are asynchronous, two flops before any use
  // the first flop may go metastable; only the second one is ever read,
  // which costs two cycles of latency on every digital read
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end else begin
      pin_meta_reg <= gp_input_pins_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end
  // input read decode by bank and port
  // an unknown bank or port gives status 3 and leaves the accumulator alone
  always @* begin
    read_val = 32'h00000000;
    read_ok = 1'b1;
    read_all = 1'b0;
    case (cmd_bank_in) // R01
      `IORAC_BANK_DIG_IN: begin
        // port 255 samples all three pins in the same cycle
        if (cmd_type_in == `IORAC_PORT_ALL) begin
          read_val = {29'h00000000, pin_sync_reg}; // R07
          read_all = 1'b1;
        end else if (cmd_type_in < 8'h03) begin
          read_val = {31'h00000000, pin_sync_reg[cmd_type_in[1:0]]}; // R06 R02
        end else begin
          read_ok = 1'b0;
        end
      end
      `IORAC_BANK_ANA_IN: begin
        // analog and digital views of input zero coexist
        // converter results are taken as already in this clock domain
        case (cmd_type_in) // R08
          8'h00: read_val = {20'h00000, gp_input_zero_adc_in}; // R02
          `IORAC_PORT_VOLT: read_val = {20'h00000, supply_tenths_in};
          `IORAC_PORT_TEMP: read_val = {20'h00000, temp_deg_in};
          default: read_ok = 1'b0;
        endcase
      end
      `IORAC_BANK_DIG_OUT: begin
        // reads back the driven flop, not the pin itself
        if (cmd_type_in == 8'h00) begin
          read_val = {31'h00000000, gp_output_zero_out}; // R09
        end else begin
          read_ok = 1'b0;
        end
      end
      default: read_ok = 1'b0;
    endcase
  end
  // single-cycle calculate ops; divide and modulo go to the divider
  // overflow is not reported, results simply wrap at 32 bits
  always @* begin
    accumulator_cmd_a_val = accum_out;
    accumulator_cmd_a_ok = 1'b1;
    case (cmd_type_in) // R11
      `IORAC_OP_ADD: accumulator_cmd_a_val = accum_out + cmd_value_in; // R17
      `IORAC_OP_SUB: accumulator_cmd_a_val = accum_out - cmd_value_in;
      `IORAC_OP_MUL: accumulator_cmd_a_val = acc_s * opr_s; // low 32 bits kept
      `IORAC_OP_AND: accumulator_cmd_a_val = accum_out & cmd_value_in;
      `IORAC_OP_OR: accumulator_cmd_a_val = accum_out | cmd_value_in;
      `IORAC_OP_XOR: accumulator_cmd_a_val = accum_out ^ cmd_value_in;
      `IORAC_OP_NOT: accumulator_cmd_a_val = ~accum_out;
      `IORAC_OP_LOAD: accumulator_cmd_a_val = cmd_value_in;
      default: accumulator_cmd_a_ok = 1'b0;
    endcase
  end
  // state sequencing
  // busy_out mirrors the state register, so a strobe while busy is dropped
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // a divide or modulo by zero is refused at once and takes the reply path
        if (cmd_valid_in && cmd_instr_in == `IORAC_CMD_ACCUM &&
            is_div_op(cmd_type_in) && cmd_value_in != 32'h00000000) begin
          state_next = ST_DIV;
        end else if (cmd_valid_in) begin
          state_next = ST_REPLY;
        end
      end
      ST_DIV: begin
        // wait for the one-cycle done pulse of the divider
        if (div_done) begin
          state_next = ST_REPLY;
        end
      end
      ST_REPLY: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  // command execution and reply registers
  // every reply field is registered; all but the rep_valid_out pulse hold until the next command or divide result
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      // all outputs low in reset, the output pin included
      state_reg <= ST_IDLE;
      accum_out <= `IORAC_ACC_RST;
      flags_out <= `IORAC_FLAGS_RST;
      gp_output_zero_out <= `IORAC_OUT_RST;
      rep_valid_out <= 1'b0;
      rep_status_out <= 8'h00;
      rep_instr_out <= 8'h00;
      rep_value_out <= 32'h00000000;
      rep_sum_out <= 8'h00;
      busy_out <= 1'b0;
      div_start_reg <= 1'b0;
      hold_type_reg <= 8'h00;
      hold_value_reg <= 32'h00000000;
      hold_sa_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rep_valid_out <= 1'b0;
      div_start_reg <= 1'b0;
      busy_out <= (state_next != ST_IDLE);
      if (state_reg == ST_IDLE && cmd_valid_in) begin
        rep_instr_out <= cmd_instr_in;
        rep_valid_out <= ~standalone_in; // replies only in direct mode
        case (cmd_instr_in)
          `IORAC_CMD_INPUT_READ: begin
            // reads finish in one cycle; the pins are already synchronised
            rep_status_out <= read_ok ? `IORAC_ST_OK : `IORAC_ST_BAD_TYPE; // R05
            rep_value_out <= read_val; // R04
            rep_sum_out <= rep_sum(read_ok ? `IORAC_ST_OK : `IORAC_ST_BAD_TYPE,
              cmd_instr_in, read_val);
            // accumulator only touched in standalone mode, or for port 255
            if (read_ok && (standalone_in || read_all)) begin
              accum_out <= read_val; // R03 R07
            end
          end
          `IORAC_CMD_ACCUM: begin
            // divide by zero refused, accumulator kept
            if (is_div_op(cmd_type_in) && cmd_value_in == 32'h00000000) begin
              rep_status_out <= `IORAC_ST_BAD_VALUE;
              rep_sum_out <= rep_sum(`IORAC_ST_BAD_VALUE, cmd_instr_in, cmd_value_in);
            end else if (is_div_op(cmd_type_in)) begin
              rep_valid_out <= 1'b0; // reply after divider finishes
              div_start_reg <= 1'b1;
              hold_type_reg <= cmd_type_in;
              hold_value_reg <= cmd_value_in;
              // the mode is latched too, in case it changes during the divide
              hold_sa_reg <= standalone_in;
            end else begin
              if (accumulator_cmd_a_ok) begin
                accum_out <= accumulator_cmd_a_val; // R12 R10
              end
              rep_status_out <= accumulator_cmd_a_ok ? `IORAC_ST_OK : `IORAC_ST_BAD_TYPE;
              rep_sum_out <= rep_sum(accumulator_cmd_a_ok ? `IORAC_ST_OK : `IORAC_ST_BAD_TYPE,
                cmd_instr_in, cmd_value_in);
            end
            rep_value_out <= cmd_value_in; // R13
          end
          `IORAC_CMD_COMPARE: begin
            // signed compare, accumulator untouched
            // the zero flag looks at the accumulator itself, not at a difference
            flags_out[`IORAC_FLAG_ZE] <= (accum_out == 32'h00000000); // R15
            flags_out[`IORAC_FLAG_EQ] <= (acc_s == opr_s); // R14
            flags_out[`IORAC_FLAG_GT] <= (acc_s > opr_s); // R17
            flags_out[`IORAC_FLAG_LT] <= (acc_s < opr_s);
            rep_status_out <= `IORAC_ST_OK;
            rep_value_out <= cmd_value_in;
            rep_sum_out <= rep_sum(`IORAC_ST_OK, cmd_instr_in, cmd_value_in);
          end
          `IORAC_CMD_OUTPUT_SET: begin
            // only bank 2 port 0 with value 0/1 is a legal output write
            // the reply value is a don't-care and goes out as zero
            if (cmd_bank_in == `IORAC_BANK_DIG_OUT && cmd_type_in == 8'h00 &&
                cmd_value_in[31:1] == 31'h00000000) begin
              gp_output_zero_out <= cmd_value_in[0]; // R16
              rep_status_out <= `IORAC_ST_OK;
              rep_sum_out <= rep_sum(`IORAC_ST_OK, cmd_instr_in, 32'h00000000);
            end else begin
              rep_status_out <= `IORAC_ST_BAD_VALUE;
              rep_sum_out <= rep_sum(`IORAC_ST_BAD_VALUE, cmd_instr_in, 32'h00000000);
            end
            rep_value_out <= 32'h00000000;
          end
          default: begin
            // unknown instruction: status 2, no state changes
            rep_status_out <= `IORAC_ST_BAD_CMD;
            rep_value_out <= 32'h00000000;
            rep_sum_out <= rep_sum(`IORAC_ST_BAD_CMD, cmd_instr_in, 32'h00000000);
          end
        endcase
      end else if (state_reg == ST_DIV && div_done) begin
        // divide result lands in accumulator, reply echoes operand
        accum_out <= (hold_type_reg == `IORAC_OP_DIV) ? div_quot : div_rem; // R12
        rep_valid_out <= ~hold_sa_reg;
        rep_status_out <= `IORAC_ST_OK;
        rep_value_out <= hold_value_reg; // R13
        rep_sum_out <= rep_sum(`IORAC_ST_OK, `IORAC_CMD_ACCUM, hold_value_reg);
      end
    end
  end
  // the divider takes the accumulator as it stands when the start pulse arrives
  iorac_divider u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .start_in(div_start_reg),
    .dividend_in(accum_out),
    .divisor_in(hold_value_reg),
    .done_out(div_done),
    .quot_out(div_quot),
    .rem_out(div_rem)
  );
endmodule // iorac_unit

/* File: verification/iorac_host_model.sv */
`timescale 1ns/1ns
// host side: hands the unit one decoded command at a time, after waiting up to 100 cycles for busy to drop
module iorac_host_model (
  // clock and unit status
  input wire clk_in,
  input wire busy_in,
  input wire rep_valid_in,
  input wire standalone_in,
  // decoded command
  output reg cmd_valid_out,
  output reg [7:0] cmd_instr_out,
  output reg [7:0] cmd_type_out,
  output reg [7:0] cmd_bank_out,
  output reg [31:0] cmd_value_out
);
  initial begin
    {cmd_valid_out, cmd_instr_out, cmd_type_out, cmd_bank_out, cmd_value_out} = 57'h0;
  end
  // a refused strobe would be lost silently, so the model waits for idle first
  task send(input [7:0] i, t, b, input [31:0] v, output reg ok);
    integer n;
    begin
      ok = 1'b0;
      for (n = 0; n < 100 && busy_in !== 1'b0; n = n + 1) @(posedge clk_in) #1;
      {cmd_valid_out, cmd_instr_out, cmd_type_out, cmd_bank_out} = {1'b1, i, t, b};
      cmd_value_out = v;
      @(posedge clk_in) #1;
      cmd_valid_out = 1'b0;
      // fields released: show the inverse, not a stale copy
      {cmd_instr_out, cmd_type_out, cmd_bank_out, cmd_value_out} = ~{i, t, b, v};
      // for single-cycle commands the reply pulse already stands right after the taking edge and lasts one cycle
      for (n = 0; n < 60 && !ok; n = n + 1) begin
        ok = rep_valid_in === 1'b1 || (standalone_in === 1'b1 && busy_in === 1'b0);
        if (!ok) @(posedge clk_in) #1;
      end
    end
  endtask
endmodule // iorac_host_model

/* File: verification/iorac_unit_assertions.sv */
`timescale 1ns/1ns
`include "iorac_defs.vh"
// port-level checks on the command unit
module iorac_unit_checker (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // command side
  input wire cmd_valid_in,
  input wire [7:0] cmd_instr_in,
  input wire [7:0] cmd_type_in,
  input wire [7:0] cmd_bank_in,
  input wire [31:0] cmd_value_in,
  input wire standalone_in,
  input wire [11:0] gp_input_zero_adc_in,
  // reply and state
  input wire rep_valid_out,
  input wire [7:0] rep_status_out,
  input wire [7:0] rep_instr_out,
  input wire [31:0] rep_value_out,
  input wire [7:0] rep_sum_out,
  input wire [31:0] accum_out,
  input wire [3:0] flags_out,
  input wire gp_output_zero_out,
  input wire busy_out
);
  // a command counts only when taken while idle
  wire take = cmd_valid_in && !busy_out;
  wire rd = take && cmd_instr_in == `IORAC_CMD_INPUT_READ;
  wire accumulator_cmd_a = take && cmd_instr_in == `IORAC_CMD_ACCUM;
  wire dir = !standalone_in;
  wire [7:0] sum = 8'h03 + rep_status_out + rep_instr_out + rep_value_out[31:24]
    + rep_value_out[23:16] + rep_value_out[15:8] + rep_value_out[7:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  digital_read_a: assert property (rd && dir && cmd_bank_in == 8'h00 && cmd_type_in < 8'h03 |=>
    rep_valid_out && rep_status_out == `IORAC_ST_OK && rep_value_out < 2 && $stable(accum_out))
    else $error("digital read reply wrong");
  analog_read_a: assert property (rd && dir && cmd_bank_in == 8'h01 && cmd_type_in == 8'h00 |=>
    rep_value_out == {20'h00000, $past(gp_input_zero_adc_in)}) else $error("analog read wrong");
  out_readback_a: assert property (rd && dir && cmd_bank_in == 8'h02 && cmd_type_in == 8'h00 |=>
    rep_value_out == {31'h0, gp_output_zero_out}) else $error("output readback wrong");
  standalone_load_a: assert property (rd && !dir && cmd_bank_in == 8'h01 && cmd_type_in == 8'h00 |=>
    accum_out == {20'h00000, $past(gp_input_zero_adc_in)} && !rep_valid_out)
    else $error("standalone read not in accumulator");
  all_inputs_a: assert property (rd && cmd_bank_in == 8'h00 && cmd_type_in == 8'hFF |=>
    accum_out[31:3] == 29'h0 && (standalone_in || accum_out == rep_value_out))
    else $error("input vector not in accumulator");
  add_result_a: assert property (accumulator_cmd_a && cmd_type_in == `IORAC_OP_ADD |=>
    accum_out == $past(accum_out) + $past(cmd_value_in)) else $error("add result wrong");
  operand_echo_a: assert property (accumulator_cmd_a && dir && cmd_type_in < 8'h03 |=>
    rep_status_out == `IORAC_ST_OK && rep_value_out == $past(cmd_value_in))
    else $error("operand not echoed");
  compare_flags_a: assert property (take && cmd_instr_in == `IORAC_CMD_COMPARE |=>
    $stable(accum_out) && flags_out[1] == ($past(accum_out) == $past(cmd_value_in)))
    else $error("compare flags or accumulator wrong");
  reply_sum_a: assert property (rep_valid_out |-> rep_sum_out == sum)
    else $error("reply checksum wrong");
  cover property (accumulator_cmd_a && cmd_type_in == `IORAC_OP_DIV);
  cover property (take && cmd_instr_in == `IORAC_CMD_COMPARE);
  cover property (rd && !dir);
endmodule // iorac_unit_checker

bind iorac_unit iorac_unit_checker chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .cmd_valid_in(cmd_valid_in), .cmd_instr_in(cmd_instr_in), .cmd_type_in(cmd_type_in),
  .cmd_bank_in(cmd_bank_in), .cmd_value_in(cmd_value_in), .standalone_in(standalone_in),
  .gp_input_zero_adc_in(gp_input_zero_adc_in), .rep_valid_out(rep_valid_out),
  .rep_status_out(rep_status_out), .rep_instr_out(rep_instr_out),
  .rep_value_out(rep_value_out), .rep_sum_out(rep_sum_out), .accum_out(accum_out),
  .flags_out(flags_out), .gp_output_zero_out(gp_output_zero_out), .busy_out(busy_out));

/* File: verification/iorac_unit_bench.sv */
`timescale 1ns/1ns
`include "iorac_defs.vh"
module iorac_unit_bench;
  reg clk_in;
  reg rst_n_in;
  reg standalone;
  reg [2:0] pins;
  reg [11:0] adc, volt, temp;
  wire cmd_valid, rep_valid, gp_output_zero, busy;
  wire [7:0] cmd_instr, cmd_type, cmd_bank, rep_status, rep_instr, rep_sum;
  wire [31:0] cmd_value, rep_value, accum;
  wire [3:0] flags;
  integer checks = 0;
  integer n_mismatch = 0;
  iorac_unit dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid),
    .cmd_instr_in(cmd_instr), .cmd_type_in(cmd_type), .cmd_bank_in(cmd_bank),
    .cmd_value_in(cmd_value), .standalone_in(standalone), .gp_input_pins_in(pins),
    .gp_input_zero_adc_in(adc), .supply_tenths_in(volt), .temp_deg_in(temp),
    .rep_valid_out(rep_valid), .rep_status_out(rep_status), .rep_instr_out(rep_instr),
    .rep_value_out(rep_value), .rep_sum_out(rep_sum), .accum_out(accum),
    .flags_out(flags), .gp_output_zero_out(gp_output_zero), .busy_out(busy));
  iorac_host_model host_u (.clk_in(clk_in), .busy_in(busy), .rep_valid_in(rep_valid),
    .standalone_in(standalone), .cmd_valid_out(cmd_valid), .cmd_instr_out(cmd_instr),
    .cmd_type_out(cmd_type), .cmd_bank_out(cmd_bank), .cmd_value_out(cmd_value));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // a reply that never comes ends the run at once
  task cmd(input [7:0] i, t, b, input [31:0] v);
    reg ok;
    begin
      host_u.send(i, t, b, v, ok);
      if (!ok) begin
        chk("reply wait", 32'h1, 32'h0);
        finish_test;
      end
    end
  endtask
  task rep(input [7:0] i, t, b, input [31:0] v, input [7:0] st, input [31:0] ev);
    begin
      cmd(i, t, b, v);
      chk("status", {24'h0, st}, {24'h0, rep_status});
      chk("instr", {24'h0, i}, {24'h0, rep_instr});
      if (st == `IORAC_ST_OK) chk("value", ev, rep_value);
      chk("sum", {24'h0, 8'h03 + st + i + rep_value[31:24] + rep_value[23:16]
        + rep_value[15:8] + rep_value[7:0]}, {24'h0, rep_sum});
    end
  endtask
  // every operation on a negative accumulator; bank byte junk must be ignored
  task t_accumulator_cmd_a;
    integer op;
    reg signed [31:0] a, b, e;
    begin
      a = -32'sd23;
      b = 32'sd5;
      for (op = 0; op < 10; op = op + 1) begin
        rep(`IORAC_CMD_ACCUM, `IORAC_OP_LOAD, 8'h5A, a, `IORAC_ST_OK, a);
        case (op)
          0: e = a + b;
          1: e = a - b;
          2: e = a * b;
          3: e = a / b;
          4: e = a % b;
          5: e = a & b;
          6: e = a | b;
          7: e = a ^ b;
          8: e = ~a;
          default: e = b;
        endcase
        rep(`IORAC_CMD_ACCUM, op[7:0], 8'h5A, b, `IORAC_ST_OK, b);
        chk("accum", e, accum);
      end
      rep(`IORAC_CMD_ACCUM, `IORAC_OP_DIV, 8'h00, 32'h0, `IORAC_ST_BAD_VALUE, 32'h0);
      chk("accum", b, accum);
      rep(`IORAC_CMD_ACCUM, 8'h0A, 8'h00, 32'h7, `IORAC_ST_BAD_TYPE, 32'h0);
      chk("accum", b, accum);
    end
  endtask
  task cmp(input [31:0] a, v, input [3:0] f);
    begin
      rep(`IORAC_CMD_ACCUM, `IORAC_OP_LOAD, 8'h00, a, `IORAC_ST_OK, a);
      cmd(`IORAC_CMD_COMPARE, 8'h33, 8'h44, v);
      chk("flags", {28'h0, f}, {28'h0, flags});
      chk("accum", a, accum);
    end
  endtask
  task t_inputs;
    integer p;
    begin
      pins = 3'b101;
      repeat (3) @(posedge clk_in);
      #1;
      for (p = 0; p < 3; p = p + 1) begin
        rep(`IORAC_CMD_INPUT_READ, p[7:0], 8'h00, 32'hFFFFFFFF, `IORAC_ST_OK, {31'h0, pins[p]});
      end
      chk("accum", 32'h0, accum);
      rep(`IORAC_CMD_INPUT_READ, 8'hFF, 8'h00, 32'h0, `IORAC_ST_OK, {29'h0, pins});
      chk("accum", {29'h0, pins}, accum);
      rep(`IORAC_CMD_INPUT_READ, 8'h03, 8'h00, 32'h0, `IORAC_ST_BAD_TYPE, 32'h0);
      rep(`IORAC_CMD_INPUT_READ, 8'h00, 8'h03, 32'h0, `IORAC_ST_BAD_TYPE, 32'h0);
    end
  endtask
  task t_analog;
    begin
      rep(`IORAC_CMD_INPUT_READ, 8'h00, 8'h01, 32'h0, `IORAC_ST_OK, {20'h0, adc});
      rep(`IORAC_CMD_INPUT_READ, 8'h08, 8'h01, 32'h0, `IORAC_ST_OK, {20'h0, volt});
      rep(`IORAC_CMD_INPUT_READ, 8'h09, 8'h01, 32'h0, `IORAC_ST_OK, {20'h0, temp});
      rep(`IORAC_CMD_INPUT_READ, 8'h03, 8'h01, 32'h0, `IORAC_ST_BAD_TYPE, 32'h0);
    end
  endtask
  task t_output;
    integer k;
    begin
      for (k = 1; k >= 0; k = k - 1) begin
        rep(`IORAC_CMD_OUTPUT_SET, 8'h00, 8'h02, k, `IORAC_ST_OK, 32'h0);
        chk("out", k, {31'h0, gp_output_zero});
        rep(`IORAC_CMD_INPUT_READ, 8'h00, 8'h02, 32'h0, `IORAC_ST_OK, k);
      end
      rep(`IORAC_CMD_OUTPUT_SET, 8'h00, 8'h02, 32'h2, `IORAC_ST_BAD_VALUE, 32'h0);
      chk("out", 32'h0, {31'h0, gp_output_zero});
      rep(8'h07, 8'h00, 8'h00, 32'h0, `IORAC_ST_BAD_CMD, 32'h0);
    end
  endtask
  // program mode: reads feed the accumulator, no reply pulse
  task t_standalone;
    begin
      standalone = 1'b1;
      cmd(`IORAC_CMD_INPUT_READ, 8'h00, 8'h01, 32'h0);
      chk("accum", {20'h0, adc}, accum);
      cmd(`IORAC_CMD_ACCUM, `IORAC_OP_ADD, 8'h00, 32'h1);
      chk("accum", {20'h0, adc} + 32'h1, accum);
      cmd(`IORAC_CMD_ACCUM, `IORAC_OP_DIV, 8'h00, 32'h2);
      chk("accum", ({20'h0, adc} + 32'h1) >> 1, accum);
      standalone = 1'b0;
    end
  endtask
  initial begin
    rst_n_in = 1'b0;
    standalone = 1'b0;
    pins = 3'b000;
    adc = 12'hFFF;
    volt = 12'h0F0;
    temp = 12'h023;
    repeat (8) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    t_accumulator_cmd_a;
    cmp(32'h5, 32'h5, 4'h2);
    cmp(32'h5, 32'h9, 4'h8);
    cmp(32'h5, 32'hFFFFFFFF, 4'h4);
    cmp(32'h0, 32'h0, 4'h3);
    t_inputs;
    t_analog;
    t_output;
    t_standalone;
    finish_test;
  end
endmodule // iorac_unit_bench
